// File: core/sarseq_top.sv
// Converter sequencer top: byte register port, start sources, channel walk and result slots
`timescale 1ns/1ps
`default_nettype none

module sarseq_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [sarseq_pkg::ADDR_W-1:0] busAddr,
    input wire logic busWrEn,
    input wire logic busRdEn,
    input wire logic [sarseq_pkg::DATA_W-1:0] busWrData,
    output logic [sarseq_pkg::DATA_W-1:0] busRdData,
    input wire logic timerTrigger,
    input wire logic extConvTriggerPin,
    input wire logic compIn,
    input wire logic moduleStop,
    output logic [3:0] analogInputSel,
    output logic sampleHold,
    output logic [sarseq_pkg::RES_W-1:0] dacCode,
    output logic convEndIrq
);

    // Control/status fields
    logic convEndFlag_ff;
    logic convEndIrqEn_ff;
    logic convStartBit_ff;
    logic scanMode_ff;
    logic channelSetSel_ff;
    logic channelGroupSel_ff;
    logic [1:0] chField_ff;

    // Control fields
    logic timerTrigEn_ff;
    logic extTrigEn_ff;

    // Flag read-as-one tracking for the clear handshake
    logic endFlagSeen_ff;

    // Sequencer
    sarseq_pkg::sarseq_seq_t seqState_ff;
    logic [1:0] chIdx_ff;
    logic coreStart_ff;
    logic [3:0] inputSel_ff;

    // Result slots and byte path
    logic [sarseq_pkg::RES_W-1:0] result_ff [sarseq_pkg::SLOTS];
    logic [sarseq_pkg::DATA_W-1:0] tempLow_ff;
    logic [sarseq_pkg::DATA_W-1:0] rdData_ff;
    logic irq_ff;
    logic extPrev_ff;

    // Synchronised pins and core handshake
    logic extSync;
    logic compSync;
    logic coreDone;
    logic [sarseq_pkg::RES_W-1:0] coreResult;

    // Decoded strobes and events
    logic wrCsr;
    logic wrCr;
    logic rdCsr;
    logic rdSlotHi;
    logic [1:0] rdSlot;
    logic extRise;
    logic trigStart;
    logic lastChan;
    logic slotDone;
    logic convEndEvt;
    logic endFlagClr;
    logic [15:0] slotWord;

    // Trigger pin and comparator come from outside the clock domain
    sarseq_sync #(
        .W(2)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn({extConvTriggerPin, compIn}),
        .syncOut({extSync, compSync})
    );

    // Conversion engine; stopping the start bit aborts the conversion in flight
    sarseq_sar_core u_core (
        .clk(clk),
        .rst(rst),
        .start(coreStart_ff),
        .abort(!convStartBit_ff),
        .compIn(compSync),
        .done(coreDone),
        .result(coreResult),
        .dacCode(dacCode),
        .sampleHold(sampleHold)
    );

    // Address decode for the 8-bit register port
    always_comb begin
        wrCsr = 1'b0;
        wrCr = 1'b0;
        rdCsr = 1'b0;
        rdSlotHi = 1'b0;
        if (busAddr == sarseq_pkg::OFS_CTRL_STATUS) begin
            wrCsr = busWrEn;
            rdCsr = busRdEn;
        end else if (busAddr == sarseq_pkg::OFS_CTRL) begin
            wrCr = busWrEn;
        end else if (busAddr <= sarseq_pkg::OFS_SLOT_D_LO) begin
            rdSlotHi = busRdEn && !busAddr[0];
        end
    end

    assign rdSlot = busAddr[2:1];
    assign slotWord = {result_ff[rdSlot], sarseq_pkg::LOW_PAD};

    // Start sources: pin edge only counts when enabled, timer pulse likewise
    assign extRise = extSync && !extPrev_ff;
    assign trigStart = (timerTrigEn_ff && timerTrigger) || (extTrigEn_ff && extRise);

    // End of pass: every single conversion, or the last channel of a scan
    assign slotDone = coreDone && (seqState_ff == sarseq_pkg::SQ_BUSY);
    assign lastChan = !scanMode_ff || (chIdx_ff == chField_ff);
    assign convEndEvt = slotDone && lastChan;

    // Clear only takes effect after the flag was read back as one
    assign endFlagClr = wrCsr && !busWrData[sarseq_pkg::CSR_END_FLAG] && endFlagSeen_ff;

    // Pin edge detector reads only the synchronised copy
    always_ff @(posedge clk) begin
        if (rst) begin
            extPrev_ff <= 1'b0;
        end else begin
            extPrev_ff <= extSync;
        end
    end

    // Mode, channel and enable fields of the control/status register
    always_ff @(posedge clk) begin
        if (rst) begin
            convEndIrqEn_ff <= 1'b0;
            scanMode_ff <= 1'b0;
            channelSetSel_ff <= 1'b0;
            channelGroupSel_ff <= 1'b0;
            chField_ff <= 2'h0;
        end else if (wrCsr) begin
            convEndIrqEn_ff <= busWrData[sarseq_pkg::CSR_IRQ_EN];
            scanMode_ff <= busWrData[sarseq_pkg::CSR_SCAN];
            channelSetSel_ff <= busWrData[sarseq_pkg::CSR_SET_SEL];
            channelGroupSel_ff <= busWrData[sarseq_pkg::CSR_GROUP_SEL];
            chField_ff <= busWrData[sarseq_pkg::CSR_CH_HI:sarseq_pkg::CSR_CH_LO];
        end
    end

    // Trigger enables of the control register
    always_ff @(posedge clk) begin
        if (rst) begin
            timerTrigEn_ff <= 1'b0;
            extTrigEn_ff <= 1'b0;
        end else if (wrCr) begin
            timerTrigEn_ff <= busWrData[sarseq_pkg::CR_TIMER_TRIG_EN];
            extTrigEn_ff <= busWrData[sarseq_pkg::CR_EXT_TRIG_EN];
        end
    end

    // Start bit: module stop beats all; a trigger beats a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            convStartBit_ff <= 1'b0;
        end else if (moduleStop) begin
            convStartBit_ff <= 1'b0;
        end else if (wrCsr) begin
            convStartBit_ff <= busWrData[sarseq_pkg::CSR_START] || trigStart;
        end else if (trigStart) begin
            convStartBit_ff <= 1'b1;
        end else if (slotDone && !scanMode_ff) begin
            convStartBit_ff <= 1'b0;
        end
    end

    // End flag: a new end event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            convEndFlag_ff <= 1'b0;
        end else if (convEndEvt) begin
            convEndFlag_ff <= 1'b1;
        end else if (endFlagClr) begin
            convEndFlag_ff <= 1'b0;
        end
    end

    // Remembers that software saw the flag set, so a blind 0 write cannot lose an event
    always_ff @(posedge clk) begin
        if (rst) begin
            endFlagSeen_ff <= 1'b0;
        end else if (endFlagClr || !convEndFlag_ff) begin
            endFlagSeen_ff <= 1'b0;
        end else if (rdCsr) begin
            endFlagSeen_ff <= 1'b1;
        end
    end

    // Channel walk: single mode uses the chosen channel, scan walks 0 up to the field
    always_ff @(posedge clk) begin
        if (rst) begin
            seqState_ff <= sarseq_pkg::SQ_IDLE;
            chIdx_ff <= 2'h0;
            coreStart_ff <= 1'b0;
        end else begin
            coreStart_ff <= 1'b0;
            case (seqState_ff)
                sarseq_pkg::SQ_IDLE: begin
                    if (convStartBit_ff) begin
                        chIdx_ff <= scanMode_ff ? 2'h0 : chField_ff;
                        seqState_ff <= sarseq_pkg::SQ_START;
                    end
                end
                sarseq_pkg::SQ_START: begin
                    if (!convStartBit_ff) begin
                        seqState_ff <= sarseq_pkg::SQ_IDLE;
                    end else begin
                        coreStart_ff <= 1'b1;
                        seqState_ff <= sarseq_pkg::SQ_BUSY;
                    end
                end
                sarseq_pkg::SQ_BUSY: begin
                    if (!convStartBit_ff) begin
                        seqState_ff <= sarseq_pkg::SQ_IDLE;
                    end else if (coreDone && scanMode_ff) begin
                        chIdx_ff <= lastChan ? 2'h0 : chIdx_ff + 2'h1;
                        seqState_ff <= sarseq_pkg::SQ_START;
                    end else if (coreDone) begin
                        seqState_ff <= sarseq_pkg::SQ_IDLE;
                    end
                end
                default: begin
                    seqState_ff <= sarseq_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    // Input select is settled before the core starts sampling
    always_ff @(posedge clk) begin
        if (rst) begin
            inputSel_ff <= 4'h0;
        end else if (seqState_ff == sarseq_pkg::SQ_START) begin
            inputSel_ff <= {channelSetSel_ff, channelGroupSel_ff, chIdx_ff};
        end
    end

    // One slot per channel position; untouched slots keep their last result
    for (genvar k = 0; k < sarseq_pkg::SLOTS; k++) begin : g_slot
        always_ff @(posedge clk) begin
            if (rst) begin
                result_ff[k] <= sarseq_pkg::RES_RST;
            end else if (slotDone && chIdx_ff == 2'(k)) begin
                result_ff[k] <= coreResult;
            end
        end
    end

    // Upper-byte read captures the lower byte, so a word read is coherent
    always_ff @(posedge clk) begin
        if (rst) begin
            tempLow_ff <= sarseq_pkg::BYTE_RST;
        end else if (rdSlotHi) begin
            tempLow_ff <= slotWord[7:0];
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_ff <= sarseq_pkg::BYTE_RST;
        end else if (busRdEn) begin
            if (busAddr == sarseq_pkg::OFS_CTRL_STATUS) begin
                rdData_ff <= {convEndFlag_ff, convEndIrqEn_ff, convStartBit_ff, scanMode_ff,
                              channelSetSel_ff, channelGroupSel_ff, chField_ff};
            end else if (busAddr == sarseq_pkg::OFS_CTRL) begin
                rdData_ff <= {timerTrigEn_ff, extTrigEn_ff, 6'h00};
            end else if (busAddr <= sarseq_pkg::OFS_SLOT_D_LO && !busAddr[0]) begin
                rdData_ff <= slotWord[15:8];
            end else if (busAddr <= sarseq_pkg::OFS_SLOT_D_LO) begin
                rdData_ff <= tempLow_ff;
            end else begin
                rdData_ff <= sarseq_pkg::BYTE_RST;
            end
        end
    end

    // Interrupt level follows the flag, gated by its enable
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= convEndFlag_ff && convEndIrqEn_ff;
        end
    end

    assign busRdData = rdData_ff;
    assign analogInputSel = inputSel_ff;
    assign convEndIrq = irq_ff;

endmodule : sarseq_top

`default_nettype wire

// File: core/sarseq_pkg.sv
// Shared constants, register map and state types for the SAR converter sequencer
`default_nettype none

package sarseq_pkg;

    // Timing of the successive-approximation steps
    localparam int CLK_MHZ = 250;
    localparam int SAMPLE_NS = 2000;
    localparam int BIT_NS = 1000;
    localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT_CYC = (BIT_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE_CYC - 1);
    localparam logic [CNT_W-1:0] BIT_LOAD = CNT_W'(BIT_CYC - 1);

    // Widths
    localparam int RES_W = 10;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int SLOTS = 4;

    // Byte addresses: slot k upper byte at 2k, lower byte at 2k+1
    localparam logic [ADDR_W-1:0] OFS_SLOT_A_HI = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SLOT_D_LO = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_CTRL_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h9;

    // Control/status register fields
    localparam int CSR_END_FLAG = 7;
    localparam int CSR_IRQ_EN = 6;
    localparam int CSR_START = 5;
    localparam int CSR_SCAN = 4;
    localparam int CSR_SET_SEL = 3;
    localparam int CSR_GROUP_SEL = 2;
    localparam int CSR_CH_HI = 1;
    localparam int CSR_CH_LO = 0;

    // Control register fields
    localparam int CR_TIMER_TRIG_EN = 7;
    localparam int CR_EXT_TRIG_EN = 6;

    // Reset values
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
    localparam logic [5:0] LOW_PAD = 6'h00;

    typedef enum logic [1:0] {SQ_IDLE, SQ_START, SQ_BUSY} sarseq_seq_t;
    typedef enum logic [1:0] {SC_IDLE, SC_SAMPLE, SC_TRIAL} sarseq_core_t;

endpackage : sarseq_pkg

`default_nettype wire

// File: core/sarseq_sync.sv
// Two-stage synchronisers for inputs arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module sarseq_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // One pair of flops per bit; the first stage feeds only the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_ff[i] <= 1'b0;
                sync_ff[i] <= 1'b0;
            end else begin
                meta_ff[i] <= asyncIn[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end

    assign syncOut = sync_ff;

endmodule : sarseq_sync

`default_nettype wire

// File: core/sarseq_sar_core.sv
// Successive-approximation engine: sample, then ten binary trials against the comparator
`timescale 1ns/1ps
`default_nettype none

module sarseq_sar_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic compIn,
    output logic done,
    output logic [sarseq_pkg::RES_W-1:0] result,
    output logic [sarseq_pkg::RES_W-1:0] dacCode,
    output logic sampleHold
);

    sarseq_pkg::sarseq_core_t state_ff;
    logic [sarseq_pkg::CNT_W-1:0] cnt_ff;
    logic [sarseq_pkg::RES_W-1:0] mask_ff;
    logic [sarseq_pkg::RES_W-1:0] dac_ff;
    logic [sarseq_pkg::RES_W-1:0] result_ff;
    logic done_ff;
    logic hold_ff;
    logic [sarseq_pkg::RES_W-1:0] kept;

    // Trial bit stays when the input is at or above the trial level
    assign kept = compIn ? dac_ff : (dac_ff & ~mask_ff);

    // Conversion sequence; abort wins so a stopped scan writes no slot unless the stop lands on the edge that raises done
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= sarseq_pkg::SC_IDLE;
            cnt_ff <= '0;
            mask_ff <= '0;
            dac_ff <= sarseq_pkg::RES_RST;
            result_ff <= sarseq_pkg::RES_RST;
            done_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (abort) begin
                state_ff <= sarseq_pkg::SC_IDLE;
                hold_ff <= 1'b0;
            end else begin
                case (state_ff)
                    sarseq_pkg::SC_IDLE: begin
                        if (start) begin
                            state_ff <= sarseq_pkg::SC_SAMPLE;
                            cnt_ff <= sarseq_pkg::SAMPLE_LOAD;
                            hold_ff <= 1'b1;
                            dac_ff <= sarseq_pkg::RES_RST;
                        end
                    end
                    sarseq_pkg::SC_SAMPLE: begin
                        if (cnt_ff == '0) begin
                            state_ff <= sarseq_pkg::SC_TRIAL;
                            hold_ff <= 1'b0;
                            mask_ff <= {1'b1, {(sarseq_pkg::RES_W-1){1'b0}}};
                            dac_ff <= {1'b1, {(sarseq_pkg::RES_W-1){1'b0}}};
                            cnt_ff <= sarseq_pkg::BIT_LOAD;
                        end else begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    sarseq_pkg::SC_TRIAL: begin
                        if (cnt_ff != '0) begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end else if (mask_ff[0]) begin
                            result_ff <= kept;
                            dac_ff <= kept;
                            done_ff <= 1'b1;
                            state_ff <= sarseq_pkg::SC_IDLE;
                        end else begin
                            dac_ff <= kept | (mask_ff >> 1);
                            mask_ff <= mask_ff >> 1;
                            cnt_ff <= sarseq_pkg::BIT_LOAD;
                        end
                    end
                    default: begin
                        state_ff <= sarseq_pkg::SC_IDLE;
                    end
                endcase
            end
        end
    end

    assign done = done_ff;
    assign result = result_ff;
    assign dacCode = dac_ff;
    assign sampleHold = hold_ff;

endmodule : sarseq_sar_core

`default_nettype wire

// File: sim/sarseq_checker_properties.sv
// Port-level timing checks of the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module sarseq_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [sarseq_pkg::ADDR_W-1:0] busAddr,
    input wire logic busWrEn,
    input wire logic busRdEn,
    input wire logic [sarseq_pkg::DATA_W-1:0] busWrData,
    input wire logic [sarseq_pkg::DATA_W-1:0] busRdData,
    input wire logic moduleStop,
    input wire logic [3:0] analogInputSel,
    input wire logic sampleHold,
    input wire logic [sarseq_pkg::RES_W-1:0] dacCode,
    input wire logic convEndIrq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [9:0] holdCnt_ff;
    logic abortSeen_ff;

    // Length of the current sample window
    always_ff @(posedge clk) begin
        if (rst || !sampleHold) begin
            holdCnt_ff <= 10'h000;
        end else begin
            holdCnt_ff <= holdCnt_ff + 10'h001;
        end
    end

    // A write or stop inside the window may cut it short, so exempt that window
    always_ff @(posedge clk) begin
        if (rst || !sampleHold) begin
            abortSeen_ff <= 1'b0;
        end else if (busWrEn || moduleStop) begin
            abortSeen_ff <= 1'b1;
        end
    end

    sequence s_irqOffWr;
        busWrEn && busAddr == 4'h8 && !busWrData[6];
    endsequence
    sequence s_noWr;
        !busWrEn ##1 (!busWrEn && convEndIrq);
    endsequence

    property p_hold_len;
        $fell(sampleHold) && !abortSeen_ff |-> holdCnt_ff == 10'h1F4;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("sample window length wrong");
    property p_sel_stable;
        sampleHold |-> $stable(analogInputSel);
    endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("input select moved while sampling");
    property p_dac_hold;
        sampleHold && $past(sampleHold) |-> $stable(dacCode);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("trial code moved while sampling");
    property p_rd_unmapped;
        busRdEn && busAddr >= 4'hA |=> busRdData == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_hold;
        !busRdEn |=> $stable(busRdData);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
    property p_low_pad;
        busRdEn && busAddr < 4'h8 && busAddr[0] |=> busRdData[5:0] == 6'h00;
    endproperty
    a_low_pad: assert property (p_low_pad) else $error("low result bits not zero");
    property p_irq_off;
        s_irqOffWr |-> ##2 !convEndIrq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("request out with enable clear");
    property p_irq_stays;
        s_noWr |=> convEndIrq;
    endproperty
    a_irq_stays: assert property (p_irq_stays) else $error("request dropped without a write");
    property p_stop_abort;
        moduleStop |-> ##[1:3] !sampleHold;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("module stop did not abort");
endmodule : sarseq_checker

`default_nettype wire

// File: sim/sarseq_analog_model.sv
// Behavioural analog side: sixteen fixed inputs, sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none

module sarseq_analog_model (
    input wire logic clk,
    input wire logic [3:0] inputSel,
    input wire logic sampleHold,
    input wire logic [sarseq_pkg::RES_W-1:0] dacCode,
    output logic compIn
);
    logic [9:0] held_ff = 10'h000;

    // Input levels as codes; both ends of the range give full-scale cases
    function automatic logic [9:0] level(input logic [3:0] i);
        if (i == 4'hF) return 10'h3FF;
        if (i == 4'h0) return 10'h000;
        return {6'h00, i} * 10'h03D + 10'h011;
    endfunction : level

    // Track while sampling, then hold so later input changes cannot skew the trials
    always @(posedge clk) begin
        if (sampleHold) begin
            held_ff <= level(inputSel);
        end
    end

    // Comparator high when the held input is at or above the trial code
    assign compIn = (held_ff >= dacCode);
endmodule : sarseq_analog_model

`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] busAddr = 4'h0;
    logic busWrEn = 1'b0;
    logic busRdEn = 1'b0;
    logic [7:0] busWrData = 8'h00;
    logic [7:0] busRdData;
    logic timerTrigger = 1'b0;
    logic extConvTriggerPin = 1'b0;
    logic compIn;
    logic moduleStop = 1'b0;
    logic [3:0] analogInputSel;
    logic sampleHold;
    logic [9:0] dacCode;
    logic convEndIrq;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;

    sarseq_top sarseq_top_inst (.clk(clk), .rst(rst), .busAddr(busAddr), .busWrEn(busWrEn),
        .busRdEn(busRdEn), .busWrData(busWrData), .busRdData(busRdData), .timerTrigger(timerTrigger),
        .extConvTriggerPin(extConvTriggerPin), .compIn(compIn), .moduleStop(moduleStop),
        .analogInputSel(analogInputSel), .sampleHold(sampleHold), .dacCode(dacCode),
        .convEndIrq(convEndIrq));
    sarseq_analog_model sarseq_analog_model_inst (.clk(clk), .inputSel(analogInputSel),
        .sampleHold(sampleHold), .dacCode(dacCode), .compIn(compIn));

    always #2 clk = ~clk;

    // Expected code of each input, kept apart from the model on purpose
    function automatic logic [9:0] exp_val(input logic [3:0] i);
        if (i == 4'hF) return 10'h3FF;
        if (i == 4'h0) return 10'h000;
        return {6'h00, i} * 10'h03D + 10'h011;
    endfunction : exp_val

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // Extra edge at the end so the next strobe never lands in the same step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        busAddr <= a;
        busWrData <= d;
        busWrEn <= 1'b1;
        @(posedge clk);
        busWrEn <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        busAddr <= a;
        busRdEn <= 1'b1;
        @(posedge clk);
        busRdEn <= 1'b0;
        @(posedge clk);
        d = busRdData;
    endtask : rd

    // Upper byte first, as the host must never read the lower byte alone
    task automatic read_slot(input logic [1:0] k, input logic [9:0] v);
        logic [7:0] d;
        rd({1'b0, k, 1'b0}, d);
        `CHK(d, v[9:2])
        rd({1'b0, k, 1'b1}, d);
        `CHK(d, {v[1:0], 6'h00})
    endtask : read_slot

    // Poll the status byte under a bound; a poll seeing the flag arms its clear
    task automatic wait_end(output logic [7:0] d);
        int n;
        n = 0;
        d = 8'h00;
        while (d[7] !== 1'b1 && n < 400) begin
            repeat (50) @(posedge clk);
            rd(4'h8, d);
            n++;
        end
    endtask : wait_end

    // Hang guard: the tests need about 25000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        logic [7:0] d;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(4'h8, d);
        `CHK(d, 8'h00)
        rd(4'h9, d);
        `CHK(d, 8'h00)
        read_slot(2'h0, 10'h000);
        $display("test reset done");
        wr(4'h8, 8'h2E);
        wait_end(d);
        `CHK(d, 8'h8E)
        `CHK(analogInputSel, 4'hE)
        read_slot(2'h2, exp_val(4'hE));
        wr(4'h8, 8'h0E);
        rd(4'h8, d);
        `CHK(d, 8'h0E)
        $display("test single done");
        wr(4'h8, 8'h73);
        wait_end(d);
        `CHK(d, 8'hF3)
        `CHK(convEndIrq, 1'b1)
        for (int k = 0; k < 4; k++) begin
            read_slot(2'(k), exp_val(4'(k)));
        end
        wr(4'h8, 8'hB3);
        // Request drops one edge after the enable, so let that edge settle first
        @(posedge clk);
        `CHK(convEndIrq, 1'b0)
        wr(4'h8, 8'h13);
        rd(4'h8, d);
        `CHK(d, 8'h13)
        $display("test scan done");
        wr(4'h9, 8'h80);
        wr(4'h8, 8'h01);
        extConvTriggerPin <= 1'b1;
        repeat (20) @(posedge clk);
        rd(4'h8, d);
        `CHK(d, 8'h01)
        extConvTriggerPin <= 1'b0;
        timerTrigger <= 1'b1;
        @(posedge clk);
        timerTrigger <= 1'b0;
        wait_end(d);
        `CHK(d, 8'h81)
        `CHK(convEndIrq, 1'b0)
        read_slot(2'h1, exp_val(4'h1));
        wr(4'h8, 8'h01);
        $display("test timer done");
        wr(4'h9, 8'h40);
        wr(4'h8, 8'h0F);
        extConvTriggerPin <= 1'b1;
        wait_end(d);
        `CHK(d, 8'h8F)
        `CHK(analogInputSel, 4'hF)
        read_slot(2'h3, 10'h3FF);
        wr(4'h8, 8'h0F);
        extConvTriggerPin <= 1'b0;
        $display("test pin done");
        wr(4'h0, 8'hFF);
        rd(4'h0, d);
        `CHK(d, 8'h00)
        rd(4'h6, d);
        `CHK(d, 8'hFF)
        rd(4'h1, d);
        `CHK(d, 8'hC0)
        rd(4'hC, d);
        `CHK(d, 8'h00)
        $display("test latch done");
        wr(4'h9, 8'h00);
        wr(4'h8, 8'h24);
        // Stop lands inside the sample window, so the abort shows on the hold line
        repeat (200) @(posedge clk);
        moduleStop <= 1'b1;
        @(posedge clk);
        moduleStop <= 1'b0;
        repeat (3500) @(posedge clk);
        rd(4'h8, d);
        `CHK(d, 8'h04)
        read_slot(2'h0, exp_val(4'h0));
        $display("test stop done");
        end_sim();
    end
endmodule : tb_top

bind sarseq_top sarseq_checker sarseq_checker_inst (.clk(clk), .rst(rst), .busAddr(busAddr),
    .busWrEn(busWrEn), .busRdEn(busRdEn), .busWrData(busWrData), .busRdData(busRdData),
    .moduleStop(moduleStop), .analogInputSel(analogInputSel), .sampleHold(sampleHold),
    .dacCode(dacCode), .convEndIrq(convEndIrq));

`default_nettype wire
